// [core/dhcs_top.sv]
// Debug halting control and status registers with debug event status.
// Functional notes
// - External debug request sets sticky flag bit 4; cleared on Cold reset.
// - Vector catch sets sticky bit 3; zero without halting debug.
// - Watchpoint event sets sticky bit 2; zero without watchpoint unit.
// - Breakpoint event sets sticky bit 1; cleared on Cold reset.
// - Halt request or single step sets sticky bit 0.
// - Control writes need key 0xA05F in upper half; otherwise ignored.
// - Clearing halt by write or restart sets restart sticky; read clears.
// - Simultaneous halt clear and set: halted again, restart sticky set.
// - Any reset sets reset sticky bit 25; read clears it.
// - Instruction retirement sets retire sticky bit 24; read clears it.
// - Secure debug status follows allowed outside Debug, frozen inside.
// - Lockup bit reads one only to debugger; clears on Debug entry.
// - Sleeping shown at bit 18; debugger halts or waits to gain control.
// - Halted status bit 17 is one in Debug state.
// - Register ready low after selector write until transfer completes.
// - Snap stall effective only with debug enable and halt in write.
// - Mask bit masks service call, tick, external irqs; never NMI.
// - Unprivileged access faults; only word accesses supported.
// - Non-secure alias readable only by secure software, otherwise RAZ/WI.
// - Event status is write-one-to-clear.
// - Halt bit halts core; set by pending debug events; Warm reset clears.
// - Debug enable writable only by debugger; zero disables other controls.
`timescale 1ns/1ps
module dhcs_top #(
	parameter logic HALT_DEBUG_IMPL = 1'b1,
	parameter logic WATCH_IMPL = 1'b1,
	parameter logic SECURITY_IMPL = 1'b1
) (
	input wire logic REF_CLK, // Processor clock.
	input wire logic RST, // Cold reset, asynchronous, active high.
	input wire logic WARM_RST, // Warm reset request, synchronous pulse.
	input wire logic REQ_VALID, // Register access strobe, one cycle.
	input wire logic REQ_WRITE, // One for write, zero for read.
	input wire logic [31:0] REQ_ADDR, // Byte address.
	input wire logic [31:0] REQ_WDATA, // Write data.
	input wire logic [2:0] REQ_SIZE, // Access size, 2 means word.
	input wire logic REQ_PRIV, // Privileged access.
	input wire logic REQ_DEBUGGER, // Access comes from the debugger.
	input wire logic REQ_SECURE, // Access made by Secure software.
	output logic RESP_VALID, // Answer strobe, two cycles after request.
	output logic [31:0] RESP_RDATA, // Read data.
	output logic RESP_FAULT, // Access faulted.
	input wire logic EXT_DBG_REQ, // External debug request event.
	input wire logic EXT_RESTART_REQ, // External restart request.
	input wire logic VECTOR_CATCH_EVENT_FLAG_EV, // Vector catch event.
	input wire logic WATCH_EV, // Watchpoint event.
	input wire logic BREAKPOINT_EVENT_FLAG_EV, // Breakpoint event.
	input wire logic STEP_EV, // Single step complete event.
	input wire logic RETIRE_EV, // One or more instructions retired.
	input wire logic IN_SECURE, // Core is in Secure state.
	input wire logic SEC_HALT_ALLOWED, // Secure halting debug allowed.
	input wire logic LOCKED_UP, // Core is locked up.
	input wire logic SLEEPING, // Core is sleeping.
	input wire logic SEL_WRITE, // Core register selector written.
	input wire logic XFER_DONE, // Core register transfer complete.
	output logic HALT_REQ, // Request core to stay in Debug state.
	output logic SNAP_STALL, // Imprecise entry allowed.
	output logic MASK_IRQ, // Mask maskable non-NMI interrupts.
	output logic MASK_SECURE_IRQ, // Mask also applies to Secure irqs.
	output logic STEP_EN, // Single step enabled.
	output logic HALTED // Core is in Debug state.
);
	logic [31:0] addr_q;
	logic [31:0] wdata_q;
	logic valid_q, write_q, priv_q, dbg_q, sec_q, word_q;
	logic halted_q, sde_q, lockup_q, regrdy_q;
	logic dbgen_q, halt_q, step_q, mask_q, snap_q;
	logic [4:0] ev_q;
	logic restart_q, reset_q, retire_q;
	logic hit_hcs, hit_des, alias_ok, acc_ok, hcs_wr, des_wr, hcs_rd;
	logic key_ok, wr_clr_halt, restart_ev, halt_set_ev, enter_ev;
	logic [4:0] ev_set, ev_clr;

	// Requests are registered so every answer comes from a flip-flop.
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			valid_q <= 1'b0;
			write_q <= 1'b0;
			addr_q <= 32'h00000000;
			wdata_q <= 32'h00000000;
			priv_q <= 1'b0;
			dbg_q <= 1'b0;
			sec_q <= 1'b0;
			word_q <= 1'b0;
		end else begin
			valid_q <= REQ_VALID;
			write_q <= REQ_WRITE;
			addr_q <= REQ_ADDR;
			wdata_q <= REQ_WDATA;
			priv_q <= REQ_PRIV | REQ_DEBUGGER;
			dbg_q <= REQ_DEBUGGER;
			sec_q <= REQ_SECURE;
			word_q <= (REQ_SIZE == 3'h2);
		end
	end

	// Alias is usable only by Secure software; others see RAZ/WI.
	always_comb begin
		alias_ok = sec_q & ~dbg_q & SECURITY_IMPL;
		hit_hcs = (addr_q == dhcs_pkg::HCS_ADDR) |
			((addr_q == dhcs_pkg::HCS_NS_ADDR) & alias_ok);
		hit_des = (addr_q == dhcs_pkg::DES_ADDR) |
			((addr_q == dhcs_pkg::DES_NS_ADDR) & alias_ok);
		// Narrow accesses are undefined; they are simply dropped here.
		acc_ok = valid_q & priv_q & word_q;
		hcs_wr = acc_ok & write_q & hit_hcs;
		hcs_rd = acc_ok & ~write_q & hit_hcs;
		des_wr = acc_ok & write_q & hit_des;
		key_ok = wdata_q[31:dhcs_pkg::KEY_LSB] == dhcs_pkg::WRITE_KEY;
		wr_clr_halt = hcs_wr & key_ok & halt_q &
			~wdata_q[dhcs_pkg::HALT_BIT];
		restart_ev = wr_clr_halt | EXT_RESTART_REQ;
		halt_set_ev = EXT_DBG_REQ | VECTOR_CATCH_EVENT_FLAG_EV | BREAKPOINT_EVENT_FLAG_EV | STEP_EV |
			(WATCH_EV & WATCH_IMPL);
		// A Warm reset wins over a debug event arriving in the same cycle.
		enter_ev = dbgen_q & (halt_q | halt_set_ev) & ~halted_q &
			~WARM_RST;
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			RESP_VALID <= 1'b0;
			RESP_FAULT <= 1'b0;
		end else begin
			RESP_VALID <= valid_q;
			RESP_FAULT <= valid_q & ~priv_q;
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			RESP_RDATA <= 32'h00000000;
		end else if (acc_ok & ~write_q & hit_hcs) begin
			RESP_RDATA <= 32'h00000000;
			RESP_RDATA[dhcs_pkg::RESTART_BIT] <= restart_q;
			RESP_RDATA[dhcs_pkg::RESET_BIT] <= reset_q;
			RESP_RDATA[dhcs_pkg::RETIRE_BIT] <= retire_q;
			RESP_RDATA[dhcs_pkg::SDE_BIT] <= sde_q;
			RESP_RDATA[dhcs_pkg::LOCKUP_BIT] <= lockup_q & dbg_q;
			RESP_RDATA[dhcs_pkg::SLEEP_BIT] <= SLEEPING;
			RESP_RDATA[dhcs_pkg::HALT_ST_BIT] <= halted_q;
			RESP_RDATA[dhcs_pkg::REGRDY_BIT] <= regrdy_q;
			RESP_RDATA[dhcs_pkg::SNAP_BIT] <= snap_q;
			RESP_RDATA[dhcs_pkg::MASK_BIT] <= mask_q;
			RESP_RDATA[dhcs_pkg::STEP_BIT] <= step_q;
			RESP_RDATA[dhcs_pkg::HALT_BIT] <= halt_q;
			RESP_RDATA[dhcs_pkg::DBGEN_BIT] <= dbgen_q;
		end else if (acc_ok & ~write_q & hit_des) begin
			RESP_RDATA <= {27'h0, ev_q};
		end else begin
			RESP_RDATA <= 32'h00000000;
		end
	end

	// Debug event flags, write-one-to-clear, set beats clear.
	always_comb begin
		ev_set[dhcs_pkg::EXT_BIT] = EXT_DBG_REQ;
		ev_set[dhcs_pkg::VECTOR_CATCH_EVENT_FLAG_BIT] = VECTOR_CATCH_EVENT_FLAG_EV & HALT_DEBUG_IMPL;
		ev_set[dhcs_pkg::WATCH_BIT] = WATCH_EV & WATCH_IMPL;
		ev_set[dhcs_pkg::BREAKPOINT_EVENT_FLAG_BIT] = BREAKPOINT_EVENT_FLAG_EV;
		ev_set[dhcs_pkg::HALTEV_BIT] = STEP_EV |
			(halt_q & dbgen_q & ~halted_q);
		ev_clr = des_wr ? wdata_q[4:0] : 5'h00;
	end

	for (genvar i = 0; i < 5; i++) begin : g_ev
		dhcs_sticky #(
			.INIT(dhcs_pkg::EVENT_INIT[i])
		) u_ev (
			.clk(REF_CLK),
			.rst(RST),
			.set(ev_set[i]),
			.clr(ev_clr[i]),
			.flag_q(ev_q[i])
		);
	end

	// Read-to-clear status; the event wins over a read in the same cycle.
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			restart_q <= 1'b0;
			reset_q <= dhcs_pkg::RESET_ST_INIT;
			retire_q <= 1'b0;
		end else begin
			if (restart_ev) begin
				restart_q <= 1'b1;
			end else if (hcs_rd) begin
				restart_q <= 1'b0;
			end
			if (WARM_RST) begin
				reset_q <= 1'b1;
			end else if (hcs_rd) begin
				reset_q <= 1'b0;
			end
			if (RETIRE_EV) begin
				retire_q <= 1'b1;
			end else if (hcs_rd) begin
				retire_q <= 1'b0;
			end
		end
	end

	// Control fields.
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			dbgen_q <= 1'b0;
			halt_q <= 1'b0;
			step_q <= 1'b0;
			mask_q <= 1'b0;
			snap_q <= 1'b0;
		end else begin
			if (hcs_wr & key_ok) begin
				if (dbg_q) begin
					dbgen_q <= wdata_q[dhcs_pkg::DBGEN_BIT];
				end
				step_q <= wdata_q[dhcs_pkg::STEP_BIT];
				mask_q <= wdata_q[dhcs_pkg::MASK_BIT];
				if (sde_q | ~SECURITY_IMPL) begin
					snap_q <= wdata_q[dhcs_pkg::SNAP_BIT] &
						wdata_q[dhcs_pkg::DBGEN_BIT] &
						wdata_q[dhcs_pkg::HALT_BIT];
				end
			end
			// A debug event beats a restart, and a restart beats a write; Warm reset beats all.
			if (WARM_RST) begin
				halt_q <= 1'b0;
			end else if (halt_set_ev & dbgen_q) begin
				halt_q <= 1'b1;
			end else if (EXT_RESTART_REQ) begin
				halt_q <= 1'b0;
			end else if (hcs_wr & key_ok) begin
				halt_q <= wdata_q[dhcs_pkg::HALT_BIT];
			end
		end
	end

	// Core state tracking.
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			halted_q <= 1'b0;
			sde_q <= 1'b0;
			lockup_q <= 1'b0;
			regrdy_q <= 1'b1;
		end else begin
			if (enter_ev) begin
				halted_q <= 1'b1;
				sde_q <= SECURITY_IMPL &
					(IN_SECURE | SEC_HALT_ALLOWED);
			// Warm reset drops the halt control, so the core leaves Debug.
			end else if (halted_q & (WARM_RST | ((restart_ev | ~dbgen_q) &
				~(halt_set_ev & dbgen_q)))) begin
				halted_q <= 1'b0;
			end else if (!halted_q) begin
				sde_q <= SECURITY_IMPL & SEC_HALT_ALLOWED;
			end
			if (enter_ev | halted_q) begin
				lockup_q <= 1'b0;
			end else begin
				lockup_q <= LOCKED_UP;
			end
			if (SEL_WRITE) begin
				regrdy_q <= 1'b0;
			end else if (XFER_DONE) begin
				regrdy_q <= 1'b1;
			end
		end
	end

	// Controls act only while debug is enabled.
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			HALT_REQ <= 1'b0;
			SNAP_STALL <= 1'b0;
			MASK_IRQ <= 1'b0;
			MASK_SECURE_IRQ <= 1'b0;
			STEP_EN <= 1'b0;
			HALTED <= 1'b0;
		end else begin
			HALT_REQ <= dbgen_q & halt_q;
			SNAP_STALL <= dbgen_q & snap_q;
			MASK_IRQ <= dbgen_q & mask_q;
			MASK_SECURE_IRQ <= dbgen_q & mask_q &
				(sde_q | ~SECURITY_IMPL);
			STEP_EN <= dbgen_q & step_q;
			HALTED <= halted_q;
		end
	end
endmodule

// [include/dhcs_pkg.sv]
// Package with offsets, field positions and reset values for the debug halt block.
package dhcs_pkg;
	localparam logic [31:0] HCS_ADDR = 32'hE000EDF0;
	localparam logic [31:0] HCS_NS_ADDR = 32'hE002EDF0;
	localparam logic [31:0] DES_ADDR = 32'hE000ED30;
	localparam logic [31:0] DES_NS_ADDR = 32'hE002ED30;
	localparam logic [15:0] WRITE_KEY = 16'hA05F;
	localparam int KEY_LSB = 16;
	localparam int EXT_BIT = 4;
	localparam int VECTOR_CATCH_EVENT_FLAG_BIT = 3;
	localparam int WATCH_BIT = 2;
	localparam int BREAKPOINT_EVENT_FLAG_BIT = 1;
	localparam int HALTEV_BIT = 0;
	localparam int RESTART_BIT = 26;
	localparam int RESET_BIT = 25;
	localparam int RETIRE_BIT = 24;
	localparam int SDE_BIT = 20;
	localparam int LOCKUP_BIT = 19;
	localparam int SLEEP_BIT = 18;
	localparam int HALT_ST_BIT = 17;
	localparam int REGRDY_BIT = 16;
	localparam int SNAP_BIT = 5;
	localparam int MASK_BIT = 3;
	localparam int STEP_BIT = 2;
	localparam int HALT_BIT = 1;
	localparam int DBGEN_BIT = 0;
	localparam logic RESET_ST_INIT = 1'b1;
	localparam logic [4:0] EVENT_INIT = 5'h00;
endpackage

// [core/dhcs_sticky.sv]
// Sticky flag: a set wins over a clear in the same cycle.
`timescale 1ns/1ps
module dhcs_sticky #(
	parameter logic INIT = 1'b0
) (
	input wire logic clk, // Clock.
	input wire logic rst, // Asynchronous reset, active high.
	input wire logic set, // Event that sets the flag.
	input wire logic clr, // Clear request.
	output logic flag_q // Flag value.
);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flag_q <= INIT;
		end else if (set) begin
			flag_q <= 1'b1;
		end else if (clr) begin
			flag_q <= 1'b0;
		end
	end
endmodule

// [bench/dhcs_top_chk.sv]
// Port checks for the debug halt control and status block.
`timescale 1ns/1ps
module dhcs_top_chk (
	input wire logic REF_CLK, // Clock.
	input wire logic RST, // Cold reset.
	input wire logic WARM_RST, // Warm reset.
	input wire logic REQ_VALID, // Strobe.
	input wire logic REQ_WRITE, // Write.
	input wire logic [31:0] REQ_ADDR, // Address.
	input wire logic [31:0] REQ_WDATA, // Data.
	input wire logic [2:0] REQ_SIZE, // Size.
	input wire logic REQ_PRIV, // Privileged.
	input wire logic REQ_DEBUGGER, // Debugger.
	input wire logic REQ_SECURE, // Secure.
	input wire logic RESP_VALID, // Answer.
	input wire logic [31:0] RESP_RDATA, // Read data.
	input wire logic RESP_FAULT, // Fault.
	input wire logic HALT_REQ, // Halt.
	input wire logic SNAP_STALL, // Snap stall.
	input wire logic MASK_IRQ, // Mask.
	input wire logic MASK_SECURE_IRQ, // Secure mask.
	input wire logic HALTED // Core in Debug state.
);
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (RST);
	resp_latency_a: assert property (REQ_VALID |-> ##2 RESP_VALID)
		else $error("Answer missing.");
	unpriv_fault_a: assert property (
		REQ_VALID && !REQ_PRIV && !REQ_DEBUGGER && REQ_SIZE == 3'h2
		|-> ##2 RESP_FAULT) else $error("No fault.");
	size_refuse_a: assert property (
		REQ_VALID && REQ_PRIV && REQ_SIZE != 3'h2
		|-> ##2 RESP_RDATA == 32'h0 && !RESP_FAULT) else $error("Size.");
	lockup_hide_a: assert property (
		REQ_VALID && !REQ_DEBUGGER |-> ##2 !RESP_RDATA[19])
		else $error("Lockup shown.");
	alias_raz_a: assert property (
		REQ_VALID && REQ_ADDR == dhcs_pkg::HCS_NS_ADDR
		&& (REQ_DEBUGGER || !REQ_SECURE) |-> ##2 RESP_RDATA == 32'h0)
		else $error("Alias read.");
	key_guard_a: assert property (
		REQ_VALID && REQ_WRITE && REQ_ADDR == dhcs_pkg::HCS_ADDR
		&& REQ_WDATA[31:16] != dhcs_pkg::WRITE_KEY
		|-> ##3 $stable(SNAP_STALL)) else $error("Keyless write.");
	snap_halt_a: assert property ($rose(SNAP_STALL) |-> HALT_REQ)
		else $error("Snap without halt.");
	secure_mask_a: assert property (MASK_SECURE_IRQ |-> MASK_IRQ)
		else $error("Secure mask alone.");
	warm_clear_a: assert property (WARM_RST |-> ##[1:2] !HALT_REQ)
		else $error("Halt kept.");
	warm_exit_a: assert property (WARM_RST |-> ##2 !HALTED)
		else $error("Debug state kept after warm reset.");
endmodule
bind dhcs_top dhcs_top_chk chk_u (.*);

// [bench/dhcs_dbg_model.sv]
// Debugger model issuing single word accesses.
`timescale 1ns/1ps
module dhcs_dbg_model (
	input wire logic clk, // Clock.
	input wire logic resp_valid, // Answer strobe.
	input wire logic [31:0] resp_rdata, // Read data.
	input wire logic resp_fault, // Fault flag.
	output logic req_valid, // Access strobe.
	output logic req_write, // Write select.
	output logic [31:0] req_addr, // Address.
	output logic [31:0] req_wdata // Write data.
);
	logic [31:0] rd_q;
	logic flt_q;
	initial {req_valid, req_write, req_addr, req_wdata} = '0;
	task automatic acc(input logic wr, input logic [31:0] ad,
		input logic [31:0] dt);
		int n;
		req_valid <= 1'b1;
		req_write <= wr;
		req_addr <= ad;
		req_wdata <= dt;
		@(posedge clk);
		// Released lines flip so stale values cannot pass for live ones.
		req_valid <= 1'b0;
		req_addr <= ~ad;
		req_wdata <= ~dt;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!resp_valid && n < 8);
		rd_q = resp_rdata;
		flt_q = resp_fault;
	endtask
	task automatic wr_ctl(input logic [15:0] c);
		acc(1'b1, dhcs_pkg::HCS_ADDR, {dhcs_pkg::WRITE_KEY, c});
	endtask
endmodule

// [bench/dhcs_top_tb.sv]
// Self-checking bench for the debug halt control and status block.
`timescale 1ns/1ps
module dhcs_top_tb;
	localparam logic [31:0] H = dhcs_pkg::HCS_ADDR;
	localparam logic [31:0] E = dhcs_pkg::DES_ADDR;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [9:0] ev = 10'h000;
	logic [3:0] lv = 4'h0;
	logic [2:0] sz = 3'h2;
	logic pv = 1'b1;
	logic dg = 1'b1;
	logic sc = 1'b0;
	logic v, w, rv, hq, ss, mi, rf, msi, st, hd;
	logic [31:0] a, d, rdat;
	int num_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #2.5 clk = ~clk;
	dhcs_top dut_u (.REF_CLK(clk), .RST(rst), .WARM_RST(ev[9]),
		.REQ_VALID(v), .REQ_WRITE(w), .REQ_ADDR(a), .REQ_WDATA(d),
		.REQ_SIZE(sz), .REQ_PRIV(pv), .REQ_DEBUGGER(dg), .REQ_SECURE(sc),
		.RESP_VALID(rv), .RESP_RDATA(rdat), .RESP_FAULT(rf),
		.EXT_DBG_REQ(ev[8]), .EXT_RESTART_REQ(ev[7]), .VECTOR_CATCH_EVENT_FLAG_EV(ev[6]),
		.WATCH_EV(ev[5]), .BREAKPOINT_EVENT_FLAG_EV(ev[4]), .STEP_EV(ev[3]),
		.RETIRE_EV(ev[2]), .IN_SECURE(lv[3]), .SEC_HALT_ALLOWED(lv[2]),
		.LOCKED_UP(lv[1]), .SLEEPING(lv[0]), .SEL_WRITE(ev[1]),
		.XFER_DONE(ev[0]), .HALT_REQ(hq), .SNAP_STALL(ss), .MASK_IRQ(mi),
		.MASK_SECURE_IRQ(msi), .STEP_EN(st), .HALTED(hd));
	dhcs_dbg_model dbg_u (.clk(clk), .resp_valid(rv), .resp_rdata(rdat),
		.resp_fault(rf),
		.req_valid(v), .req_write(w), .req_addr(a), .req_wdata(d));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic rd(input logic [31:0] ad, input logic [31:0] m,
		input logic [31:0] e);
		dbg_u.acc(1'b0, ad, 32'h0);
		chk(dbg_u.rd_q & m, e);
	endtask
	task automatic pulse(input logic [9:0] p);
		ev <= p;
		@(posedge clk);
		ev <= 10'h000;
		@(posedge clk);
	endtask
	task automatic stop_test;
		$display("Compares %0d, errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// The whole sequence needs about 150 cycles; this leaves margin.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			num_errors++;
			stop_test();
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		lv <= 4'h4;
		rd(H, 32'h0200_0000, 32'h0200_0000);
		rd(H, 32'h0200_0000, 32'h0000_0000);
		dbg_u.wr_ctl(16'h0021);
		@(posedge clk);
		chk({31'h0, ss}, 32'h0);
		dbg_u.wr_ctl(16'h0023);
		rd(H, 32'h0002_0023, 32'h0002_0023);
		chk({31'h0, ss}, 32'h1);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(H, 32'h0200_0023, 32'h0200_0000);
		dbg_u.acc(1'b1, H, 32'h1234_0003);
		rd(H, 32'h0000_0003, 32'h0000_0000);
		dg <= 1'b0;
		dbg_u.wr_ctl(16'h0001);
		dg <= 1'b1;
		rd(H, 32'h0000_0001, 32'h0000_0000);
		dbg_u.wr_ctl(16'h0003);
		rd(H, 32'h0002_0003, 32'h0002_0003);
		chk({30'h0, hq, hd}, 32'h3);
		dbg_u.wr_ctl(16'h000F);
		rd(H, 32'h0000_000C, 32'h0000_000C);
		chk({29'h0, mi, msi, st}, 32'h7);
		pulse(10'h002);
		rd(H, 32'h0001_0000, 32'h0000_0000);
		pulse(10'h001);
		rd(H, 32'h0001_0000, 32'h0001_0000);
		dbg_u.wr_ctl(16'h0009);
		rd(H, 32'h0402_0002, 32'h0400_0000);
		rd(H, 32'h0400_0000, 32'h0000_0000);
		dbg_u.wr_ctl(16'h000B);
		pulse(10'h180);
		rd(H, 32'h0402_0002, 32'h0402_0002);
		dbg_u.acc(1'b1, E, 32'h0000_001F);
		pulse(10'h178);
		rd(E, 32'hFFFF_FFFF, 32'h0000_001F);
		dbg_u.acc(1'b1, E, 32'h0000_0005);
		rd(E, 32'hFFFF_FFFF, 32'h0000_001A);
		pulse(10'h004);
		rd(H, 32'h0100_0000, 32'h0100_0000);
		pulse(10'h200);
		rd(H, 32'h0200_0002, 32'h0200_0000);
		chk({31'h0, hd}, 32'h0);
		lv <= 4'h7;
		rd(H, 32'h001E_0000, 32'h001C_0000);
		dg <= 1'b0;
		rd(H, 32'h0008_0000, 32'h0000_0000);
		pv <= 1'b0;
		dbg_u.acc(1'b0, H, 32'h0);
		chk({31'h0, dbg_u.flt_q}, 32'h1);
		pv <= 1'b1;
		sz <= 3'h1;
		rd(H, 32'hFFFF_FFFF, 32'h0000_0000);
		dg <= 1'b1;
		sz <= 3'h2;
		rd(dhcs_pkg::HCS_NS_ADDR, 32'hFFFF_FFFF, 32'h0);
		dg <= 1'b0;
		sc <= 1'b1;
		rd(dhcs_pkg::HCS_NS_ADDR, 32'h0000_0009, 32'h0000_0009);
		dg <= 1'b1;
		sc <= 1'b0;
		lv <= 4'h0;
		rd(H, 32'h0010_0000, 32'h0000_0000);
		chk({30'h0, mi, msi}, 32'h2);
		lv <= 4'h8;
		dbg_u.wr_ctl(16'h000B);
		rd(H, 32'h0012_000B, 32'h0012_000B);
		chk({30'h0, hd, msi}, 32'h3);
		stop_test();
	end
endmodule
